// [pkg/ptimer_pkg.sv]
/*
 * Shared constants and types for the periodic timer register block.
 * Assumes an 8-bit register port with one-cycle strobes and a single clock.
 */
`default_nettype none
package ptimer_pkg;
  localparam int CNT_W = 10;
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] OFS_ON_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_MODE_CTRL = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CNT_LO = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_CNT_HI = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_CMPA_LO = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_CMPA_HI = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_PER_LO = 3'h6;
  localparam logic [ADDR_W-1:0] OFS_PER_HI = 3'h7;
  localparam int ON_BIT = 3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [CNT_W-1:0] RST_CNT = 10'h000;
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  localparam logic [1:0] PF_NONE = 2'h0;
  localparam logic [1:0] PF_LOW = 2'h1;
  localparam logic [1:0] PF_HIGH = 2'h2;
  localparam logic [1:0] PF_TOG = 2'h3;

  typedef struct packed {
    logic [1:0] mode_select;
    logic [1:0] pin_function_select;
    logic output_level_control;
    logic output_invert;
    logic capture_source_select;
    logic clear_source_select;
  } mode_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : ptimer_pkg
`default_nettype wire

// [logic/periodic_timer.sv]
/*
 * Periodic 10-bit timer: mode control, compare, period, capture and output pin.
 * Assumes a bus master that issues one-cycle read or write strobes, and
 * asynchronous timer pins that are synchronised here before use.
 */
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`default_nettype none
// Functional notes
// - Mode field: 00 compare, 01 capture, 10 PWM/pulse, 11 plain timer.
// - Plain timer mode never drives the output pin.
// - Compare mode: A match leaves, clears, sets or toggles the pin.
// - PWM mode: forced inactive, forced active, PWM, or single pulse.
// - Capture on rising, falling, both edges, or not at all.
// - Timer-on rising edge restores the initial pin level.
// - Compare mode: level bit gives initial low or high.
// - PWM mode: level bit selects active low or active high.
// - Single pulse: level bit gives pin level at timer-on rise.
// - Invert bit inverts the pin; no effect in plain timer mode.
// - Capture source: timer pin at 0, external clock pin at 1.
// - Clear source 1 clears counter on compare A match.
// - Clear source 0 clears on period match or overflow.
// - Overflow clear happens only when period value is zero.
// - Clear source ignored in PWM, pulse and capture modes.
// - Counter readable as low byte and two-bit high byte.
// - Unused high bits of the high bytes read as zero.
// - Compare A value is read/write, low and high byte.
// - Period low byte is read/write.
// - Period high byte holds period bits 9 to 8.
// - Timer-on rise zeroes the counter; fall stops and holds it.
module periodic_timer
  import ptimer_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Timer pins.
  input wire logic timer_io_pin_i,
  input wire logic external_clock_pin_i,
  output logic timer_io_pin_o,
  output logic timer_io_pin_oe_o
);

  reg_req_t req;
  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  function automatic logic hit(input reg_req_t r, input logic [ADDR_W-1:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction : hit

  // Pin synchronisers; stage one feeds only stage two.
  logic [1:0] io_s1_r, io_s1_nxt, io_s2_r, io_s2_nxt, io_s3_r, io_s3_nxt;
  always_comb begin
    io_s1_nxt = {external_clock_pin_i, timer_io_pin_i};
    io_s2_nxt = io_s1_r;
    io_s3_nxt = io_s2_r;
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      io_s1_r <= 2'h0;
      io_s2_r <= 2'h0;
      io_s3_r <= 2'h0;
    end else begin
      io_s1_r <= io_s1_nxt;
      io_s2_r <= io_s2_nxt;
      io_s3_r <= io_s3_nxt;
    end
  end

  // Registers and timer state.
  logic on_r, on_nxt;
  mode_ctrl_t mc_r, mc_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, cmpa_r, cmpa_nxt, per_r, per_nxt;
  logic pin_r, pin_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic oe_r, oe_nxt;

  logic on_rise, match_a, match_p, ovf, cap_edge, cap_trig, pulse_mode, pwm_lvl;
  logic [CNT_W-1:0] per_eff;
  logic init_lvl;

  always_comb begin
    on_rise = hit(req, OFS_ON_CTRL) && reg_wdata_i[ON_BIT] && !on_r;
    match_a = on_r && (cnt_r == cmpa_r);
    match_p = on_r && (cnt_r == per_r) && (per_r != RST_CNT);
    ovf = on_r && (cnt_r == {CNT_W{1'b1}});
    pulse_mode = (mc_r.mode_select == MODE_PWM) && (mc_r.pin_function_select == PF_TOG);
    init_lvl = mc_r.output_level_control;
    cap_edge = 1'b0;
    cap_trig = 1'b0;
    if (mc_r.capture_source_select) begin
      cap_edge = io_s2_r[1] ^ io_s3_r[1];
      cap_trig = io_s2_r[1];
    end else begin
      cap_edge = io_s2_r[0] ^ io_s3_r[0];
      cap_trig = io_s2_r[0];
    end
    // PWM active while counter is below the duty value; full duty at or above period.
    per_eff = per_r;
    pwm_lvl = (cnt_r < cmpa_r) || ((per_r != RST_CNT) && (cmpa_r >= per_eff));
    pwm_lvl = pwm_lvl ? init_lvl : !init_lvl;
  end

  // Mode register, compare and period bytes.
  always_comb begin
    mc_nxt = mc_r;
    cmpa_nxt = cmpa_r;
    per_nxt = per_r;
    if (hit(req, OFS_MODE_CTRL)) begin
      mc_nxt = mode_ctrl_t'(reg_wdata_i);
    end
    if (hit(req, OFS_CMPA_LO)) begin
      cmpa_nxt[7:0] = reg_wdata_i;
    end
    if (hit(req, OFS_CMPA_HI)) begin
      cmpa_nxt[9:8] = reg_wdata_i[1:0];
    end
    if (hit(req, OFS_PER_LO)) begin
      per_nxt[7:0] = reg_wdata_i;
    end
    if (hit(req, OFS_PER_HI)) begin
      per_nxt[9:8] = reg_wdata_i[1:0];
    end
    // capture edge choice; hardware capture wins over a same-cycle write.
    if (on_r && (mc_r.mode_select == MODE_CAP) && cap_edge) begin
      case (mc_r.pin_function_select)
        PF_NONE: if (cap_trig) cmpa_nxt = cnt_r;
        PF_LOW: if (!cap_trig) cmpa_nxt = cnt_r;
        PF_HIGH: cmpa_nxt = cnt_r;
        default: cmpa_nxt = cmpa_nxt;
      endcase
    end
  end

  // Counter and on control.
  always_comb begin
    on_nxt = on_r;
    cnt_nxt = cnt_r;
    if (hit(req, OFS_ON_CTRL)) begin
      on_nxt = reg_wdata_i[ON_BIT];
    end
    if (on_r) begin
      cnt_nxt = cnt_r + 10'h001;
      case (mc_r.mode_select)
        MODE_CMP, MODE_TMR: begin
          if (mc_r.clear_source_select) begin
            if (match_a) cnt_nxt = RST_CNT;
          end else begin
            if (match_p) cnt_nxt = RST_CNT;
            // overflow clear only when period zero
            if (ovf && per_r == RST_CNT) cnt_nxt = RST_CNT;
          end
        end
        default: begin
          if (match_p) cnt_nxt = RST_CNT;
          // Single pulse ends on compare A and drops the on control.
          if (pulse_mode && match_a) on_nxt = 1'b0;
        end
      endcase
    end
    // counter zeroed on start, held when stopped
    if (on_rise) begin
      cnt_nxt = RST_CNT;
    end
    // counter readout writes have no path here
  end

  // Output pin.
  always_comb begin
    pin_nxt = pin_r;
    oe_nxt = 1'b1;
    case (mc_r.mode_select)
      MODE_CMP: begin
        if (match_a) begin
          case (mc_r.pin_function_select)
            PF_LOW: pin_nxt = 1'b0;
            PF_HIGH: pin_nxt = 1'b1;
            PF_TOG: pin_nxt = !pin_r;
            default: pin_nxt = pin_r;
          endcase
        end
        if (on_rise) pin_nxt = init_lvl;
      end
      MODE_PWM: begin
        case (mc_r.pin_function_select)
          PF_NONE: pin_nxt = !init_lvl;
          PF_LOW: pin_nxt = init_lvl;
          PF_HIGH: pin_nxt = on_r ? pwm_lvl : !init_lvl;
          default: pin_nxt = (on_r && !match_a) ? init_lvl : !init_lvl;
        endcase
        // single pulse starts at level bit
        if (on_rise) pin_nxt = pulse_mode ? init_lvl : !init_lvl;
      end
      MODE_CAP: begin
        oe_nxt = 1'b0;
      end
      default: begin
        oe_nxt = 1'b0;
      end
    endcase
  end

  // Read data, one cycle after the strobe.
  always_comb begin
    rdata_nxt = RST_BYTE;
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_ON_CTRL: rdata_nxt = {4'h0, on_r, 3'h0};
        OFS_MODE_CTRL: rdata_nxt = mc_r;
        OFS_CNT_LO: rdata_nxt = cnt_r[7:0];
        OFS_CNT_HI: rdata_nxt = {6'h00, cnt_r[9:8]};
        OFS_CMPA_LO: rdata_nxt = cmpa_r[7:0];
        OFS_CMPA_HI: rdata_nxt = {6'h00, cmpa_r[9:8]};
        OFS_PER_LO: rdata_nxt = per_r[7:0];
        OFS_PER_HI: rdata_nxt = {6'h00, per_r[9:8]};
        default: rdata_nxt = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      on_r <= 1'b0;
      mc_r <= mode_ctrl_t'(RST_BYTE);
      cnt_r <= RST_CNT;
      cmpa_r <= RST_CNT;
      per_r <= RST_CNT;
      pin_r <= 1'b0;
      oe_r <= 1'b1;
      rdata_r <= RST_BYTE;
    end else begin
      on_r <= on_nxt;
      mc_r <= mc_nxt;
      cnt_r <= cnt_nxt;
      cmpa_r <= cmpa_nxt;
      per_r <= per_nxt;
      pin_r <= pin_nxt;
      oe_r <= oe_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // invert applied at the pin; oe low hides it in timer mode
  logic pin_out_r, pin_out_nxt;
  assign pin_out_nxt = pin_nxt ^ mc_nxt.output_invert;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_out_r <= 1'b0;
    end else begin
      pin_out_r <= pin_out_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign timer_io_pin_o = pin_out_r;
  assign timer_io_pin_oe_o = oe_r;

  AST_TMR_NO_DRIVE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (mc_r.mode_select == MODE_TMR) |=> !timer_io_pin_oe_o)
    else $error("pin driven in timer mode");
  AST_START_ZERO: assert property (@(posedge core_clk_i) disable iff (rst_i)
    on_rise |=> (cnt_r == RST_CNT))
    else $error("counter not zeroed on start");
  AST_STOP_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!on_r && !on_rise) |=> $stable(cnt_r))
    else $error("stopped counter moved");
  AST_CLR_A: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (match_a && !on_rise && mc_r.clear_source_select && mc_r.mode_select == MODE_CMP)
    |=> cnt_r == RST_CNT)
    else $error("no clear on compare A");
  AST_CLR_P: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (match_p && !on_rise && !mc_r.clear_source_select && mc_r.mode_select == MODE_CMP)
    |=> cnt_r == RST_CNT)
    else $error("no clear on period match");
  AST_HI_ZERO: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i[0] && reg_addr_i != OFS_MODE_CTRL)
    |=> reg_rdata_o[7:2] == 6'h00)
    else $error("high byte upper bits not zero");
  AST_CNT_RD: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == OFS_CNT_LO) |=> reg_rdata_o == $past(cnt_r[7:0]))
    else $error("counter low readout wrong");
  AST_INIT_LVL: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (on_rise && mc_r.mode_select == MODE_CMP && !hit(req, OFS_MODE_CTRL))
    |=> pin_r == $past(init_lvl))
    else $error("initial level not restored");
  AST_TOGGLE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (match_a && !on_rise && mc_r.mode_select == MODE_CMP && mc_r.pin_function_select == PF_TOG)
    |=> pin_r != $past(pin_r))
    else $error("toggle missing");
  AST_PER_WR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    hit(req, OFS_PER_HI) |=> per_r[9:8] == $past(reg_wdata_i[1:0]))
    else $error("period high write lost");
  AST_CAP_NO_DRIVE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (mc_r.mode_select == MODE_CAP) |=> !timer_io_pin_oe_o)
    else $error("pin driven in capture mode");
  AST_CMP_DRIVE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (mc_r.mode_select == MODE_CMP) |=> timer_io_pin_oe_o)
    else $error("pin not driven in compare mode");
  AST_PWM_INACT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (mc_r.mode_select == MODE_PWM && mc_r.pin_function_select == PF_NONE && !on_rise)
    |=> pin_r == !$past(init_lvl))
    else $error("forced inactive level wrong");
  AST_PWM_ACT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (mc_r.mode_select == MODE_PWM && mc_r.pin_function_select == PF_LOW && !on_rise)
    |=> pin_r == $past(init_lvl))
    else $error("forced active level wrong");
  AST_PULSE_END: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (pulse_mode && match_a) |=> !on_r)
    else $error("single pulse did not stop");
  AST_PULSE_START: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (pulse_mode && on_rise) |=> pin_r == $past(init_lvl))
    else $error("single pulse start level wrong");
  AST_INVERT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    timer_io_pin_o == (pin_r ^ mc_r.output_invert))
    else $error("pin invert wrong");
  AST_CAP_BOTH: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (on_r && mc_r.mode_select == MODE_CAP && mc_r.pin_function_select == PF_HIGH && cap_edge)
    |=> cmpa_r == $past(cnt_r))
    else $error("capture on either edge missing");
  AST_CAP_OFF: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (mc_r.mode_select == MODE_CAP && mc_r.pin_function_select == PF_TOG
     && !hit(req, OFS_CMPA_LO) && !hit(req, OFS_CMPA_HI)) |=> $stable(cmpa_r))
    else $error("capture while disabled");
  AST_CAP_SRC: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (mc_r.capture_source_select && io_s2_r[1] == io_s3_r[1]
     && !hit(req, OFS_CMPA_LO) && !hit(req, OFS_CMPA_HI)) |=> $stable(cmpa_r))
    else $error("capture from unselected pin");
  AST_CLR_IGNORED: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (match_p && !on_rise && (mc_r.mode_select == MODE_PWM || mc_r.mode_select == MODE_CAP))
    |=> cnt_r == RST_CNT)
    else $error("period match did not clear");
  AST_PER_LO_WR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    hit(req, OFS_PER_LO) |=> per_r[7:0] == $past(reg_wdata_i))
    else $error("period low write lost");
  AST_CMPA_HI_WR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (hit(req, OFS_CMPA_HI) && mc_r.mode_select != MODE_CAP)
    |=> cmpa_r[9:8] == $past(reg_wdata_i[1:0]))
    else $error("compare A high write lost");
  AST_RO_WRITE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ((hit(req, OFS_CNT_LO) || hit(req, OFS_CNT_HI)) && !on_r) |=> $stable(cnt_r))
    else $error("counter readout write took effect");
  AST_NO_CHANGE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (match_a && !on_rise && mc_r.mode_select == MODE_CMP && mc_r.pin_function_select == PF_NONE)
    |=> $stable(pin_r))
    else $error("pin moved with no action set");
  AST_RD_IDLE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !reg_rd_i |=> reg_rdata_o == RST_BYTE)
    else $error("read data left standing");

endmodule : periodic_timer
`default_nettype wire

// [verif/pin_partner.sv]
/*
 * Behavioural model of the two timer pins outside the block.
 * Assumes the bench calls drive just after a rising clock edge.
 */
`default_nettype none
module pin_partner (
  // Design side of the shared timer pin.
  input wire logic pin_oe_i,
  input wire logic pin_out_i,
  // Levels seen by the design.
  output logic io_level_o,
  output logic ext_clk_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic io_drv_r = 1'b0;
  logic ck_drv_r = 1'b0;
  // The model lets go of the shared pin while the timer drives it, so no contention is modelled.
  assign io_level_o = pin_oe_i ? pin_out_i : io_drv_r;
  assign ext_clk_o = ck_drv_r;
  task automatic drive(input logic io_v, input logic ck_v);
    io_drv_r <= io_v;
    ck_drv_r <= ck_v;
  endtask : drive
endmodule : pin_partner
`default_nettype wire

// [verif/testbench.sv]
/*
 * Self-checking bench for the periodic timer block.
 * Assumes the timer package and the pin partner model are compiled first.
 */
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench
  import ptimer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [1:0] k; logic [7:0] e;} note_t;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, smp = 1'b0, rd_q = 1'b0, smp_q = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic pin, oe, io, ck, lvl, inv;
  int bad_count = 0;
  int checks_done = 0;
  note_t notes[$];

  periodic_timer i_periodic_timer (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .timer_io_pin_i(io), .external_clock_pin_i(ck), .timer_io_pin_o(pin),
    .timer_io_pin_oe_o(oe));
  pin_partner i_pin_partner (.pin_oe_i(oe), .pin_out_i(pin), .io_level_o(io), .ext_clk_o(ck));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // Kind 0 is equality, kind 1 is at most, kind 2 is differs from.
  always @(posedge clk) begin
    rd_q <= rd;
    smp_q <= smp;
    if (rd_q || smp_q) begin
      logic [7:0] g;
      note_t n;
      n = notes.pop_front();
      g = rd_q ? rdata : {6'h00, oe, pin};
      if (n.k == 2'h1) g = {7'h00, g <= n.e};
      if (n.k == 2'h2) g = {7'h00, g != n.e};
      `CHK(g, n.k == 2'h0 ? n.e : 8'h01)
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic op(input logic w, input logic r, input logic s,
                    input logic [ADDR_W-1:0] a, input logic [7:0] d);
    wr <= w;
    rd <= r;
    smp <= s;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask : op
  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, 1'b0, a, d);
  endtask : wreg
  task automatic rreg(input logic [ADDR_W-1:0] a, input logic [1:0] k, input logic [7:0] e);
    notes.push_back({k, e});
    op(1'b0, 1'b1, 1'b0, a, 8'h00);
  endtask : rreg
  task automatic spin(input logic [1:0] k, input logic [7:0] e);
    notes.push_back({k, e});
    op(1'b0, 1'b0, 1'b1, addr, wdata);
  endtask : spin
  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 1'b0, addr, wdata);
  endtask : idle
  // The timer is always switched off before its mode or pin function changes.
  task automatic start(input logic [7:0] mc, input logic [9:0] ca);
    wreg(OFS_ON_CTRL, 8'h00);
    wreg(OFS_MODE_CTRL, mc);
    wreg(OFS_CMPA_LO, ca[7:0]);
    wreg(OFS_CMPA_HI, {6'h00, ca[9:8]});
    wreg(OFS_ON_CTRL, 8'h08);
  endtask : start
  task automatic period(input logic [9:0] p);
    wreg(OFS_PER_LO, p[7:0]);
    wreg(OFS_PER_HI, {6'h00, p[9:8]});
  endtask : period

  initial begin
    #100000;
    bad_count++;
    summarize();
  end

  initial begin
    logic [7:0] r;
    logic [1:0] pf;
    logic cap;
    r = 8'($urandom(54));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 8; a++) rreg(a[ADDR_W-1:0], 2'h0, RST_BYTE);
    spin(2'h0, 8'h02);
    for (int a = 1; a < 8; a++) begin
      r = 8'($urandom);
      wreg(a[ADDR_W-1:0], r);
      rreg(a[ADDR_W-1:0], 2'h0, (a == 2 || a == 3) ? 8'h00 : (a == 5 || a == 7) ? r & 8'h03 : r);
    end
    period(10'h000);
    start({MODE_TMR, r[5:1], 1'b0}, 10'h000);
    rreg(OFS_CNT_LO, 2'h0, 8'h00);
    spin(2'h1, 8'h01);
    idle(297);
    rreg(OFS_CNT_LO, 2'h0, 8'h2B);
    rreg(OFS_CNT_HI, 2'h0, 8'h01);
    idle(728);
    rreg(OFS_CNT_LO, 2'h0, 8'h05);
    period(10'h005);
    start({MODE_CMP, 6'h00}, 10'h3FF);
    idle(40);
    rreg(OFS_CNT_LO, 2'h1, 8'h05);
    period(10'h000);
    start({MODE_CMP, 6'h01}, 10'h007);
    idle(40);
    rreg(OFS_CNT_LO, 2'h1, 8'h07);
    period(10'h009);
    start({MODE_PWM, PF_HIGH, 4'h1}, 10'h003);
    idle(4);
    rreg(OFS_CNT_LO, 2'h0, 8'h04);
    wreg(OFS_ON_CTRL, 8'h00);
    idle(2);
    rreg(OFS_CNT_LO, 2'h0, 8'h06);
    wreg(OFS_CNT_LO, 8'hFF);
    wreg(OFS_CNT_HI, 8'h03);
    rreg(OFS_CNT_LO, 2'h0, 8'h06);
    rreg(OFS_CNT_HI, 2'h0, 8'h00);
    wreg(OFS_ON_CTRL, 8'h08);
    rreg(OFS_CNT_LO, 2'h0, 8'h00);
    period(10'h000);
    for (int i = 0; i < 8; i++) begin
      pf = 2'(i >> 1);
      lvl = i[0];
      inv = 1'($urandom);
      start({MODE_CMP, pf, lvl, inv, 2'h0}, 10'd10);
      idle(2);
      spin(2'h0, {7'h01, lvl ^ inv});
      idle(15);
      // an action equal to the start level leaves the pin where it was.
      r[0] = pf == PF_NONE ? lvl : pf == PF_LOW ? 1'b0 : pf == PF_HIGH ? 1'b1 : ~lvl;
      spin(2'h0, {7'h01, r[0] ^ inv});
    end
    period(10'd20);
    for (int i = 0; i < 5; i++) begin
      pf = i > 3 ? 2'h3 : i > 1 ? 2'h2 : 2'(i);
      lvl = 1'($urandom);
      inv = 1'($urandom);
      start({MODE_PWM, pf, lvl, inv, 2'h0}, i == 4 ? 10'd12 : i[0] ? 10'h000 : 10'h3FF);
      idle(2);
      spin(2'h0, {7'h01, ~((i == 1 || i == 2 || i == 4) ^ lvl ^ inv)});
      idle(21);
      spin(2'h0, {7'h01, ~((i == 1 || i == 2) ^ lvl ^ inv)});
      rreg(OFS_ON_CTRL, 2'h0, i == 4 ? 8'h00 : 8'h08);
    end
    for (int i = 0; i < 8; i++) begin
      pf = 2'(i >> 1);
      i_pin_partner.drive(1'b0, 1'b0);
      start({MODE_CAP, pf, 2'h0, i[0], 1'b0}, 10'h3FF);
      idle(10);
      for (int e = 0; e < 3; e++) begin
        wreg(OFS_CMPA_LO, 8'hFF);
        i_pin_partner.drive(e == 1 ? 1'b1 : i[0], e == 1 ? 1'b1 : ~i[0]);
        idle(10);
        cap = e == 1 ? (pf == 2'h0 || pf == 2'h2) : e == 2 ? (pf == 2'h1 || pf == 2'h2) : 1'b0;
        rreg(OFS_CMPA_LO, cap ? 2'h2 : 2'h0, 8'hFF);
      end
    end
    idle(2);
    summarize();
  end
endmodule : testbench
`default_nettype wire
